/* pkg/sap_params.svh */
// Offsets, field positions, reset values and timing counts of the serial audio port
`ifndef SAP_PARAMS_SVH
`define SAP_PARAMS_SVH

`define SAP_ADDR_CTRL       4'h0
`define SAP_ADDR_STATUS     4'h4

`define SAP_CTRL_HOST       7
`define SAP_CTRL_MODE_LSB   0
`define SAP_CTRL_FMT_LSB    2
`define SAP_CTRL_DIV_LSB    4
`define SAP_CTRL_RESET      8'h00

`define SAP_STARTUP_MCLK    524288

`define SAP_MODE_SLAVE      2'h3
`define SAP_DET_SINGLE_MIN  16'h00C0
`define SAP_DET_DOUBLE_MIN  16'h0060

`define SAP_SHIFT_2CH       4'h8
`define SAP_SHIFT_TDM       4'hA
`define SAP_LAST_BIT_2CH    8'h3F
`define SAP_LAST_BIT_TDM    8'hFF

`endif

/* pkg/sap_pkg.sv */
// Types shared by the serial audio port design
package sap_pkg;
  typedef enum logic [1:0] {
    SAP_FMT_LJ   = 2'h0,
    SAP_FMT_I2S  = 2'h1,
    SAP_FMT_TDM  = 2'h2,
    SAP_FMT_RSVD = 2'h3
  } sap_fmt_t;

  typedef enum logic [1:0] {
    SAP_SPD_SINGLE = 2'h0,
    SAP_SPD_DOUBLE = 2'h1,
    SAP_SPD_QUAD   = 2'h2
  } sap_speed_t;

  typedef enum logic [1:0] {
    SAP_RUN_LATCH,
    SAP_RUN_WAIT,
    SAP_RUN_LIVE
  } sap_run_t;
endpackage : sap_pkg

/* design/sap_sample_mem.sv */
// Four-entry sample store with one write port and two registered read ports
`timescale 1ns/1ps
module sap_sample_mem #(
  parameter int W     = 24,
  parameter int DEPTH = 4,
  parameter int AW    = 2
) (
  // Clock and reset
  input  wire logic          mclk,
  input  wire logic          nrst,
  // Write side
  input  wire logic          wr,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [W-1:0]  wr_data,
  // Read side
  input  wire logic [AW-1:0] rd_addr_a,
  input  wire logic [AW-1:0] rd_addr_b,
  output logic      [W-1:0]  rd_data_a,
  output logic      [W-1:0]  rd_data_b
);
  logic [W-1:0] mem [DEPTH];

  always_ff @(posedge mclk) begin
    if (wr) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rd_data_a <= '0;
      rd_data_b <= '0;
    end else begin
      rd_data_a <= mem[rd_addr_a];
      rd_data_b <= mem[rd_addr_b];
    end
  end
endmodule : sap_sample_mem

/* design/sap_port.sv */
// Serial audio output port: clock master/slave, LJ / I2S / TDM formats, speed detect
// Behaviour
// - An external master clock is only an input; the block never drives it.
// - Master: bit clock and frame clock derived from master clock and driven out.
// - Mode 00/01/10 select master at single, double or quad rate.
// - Mode 11 selects slave with automatic speed range detection.
// - Slave speed comes from divided master clock versus frame clock ratio.
// - Slave applies the configured master clock divider before the ratio count.
// - Port has bit clock, frame clock and four serial data lines.
// - Format 00 left-justified, 01 I2S, 10 TDM, 11 reserved.
// - Two-channel formats send odd channel then even, MSB first.
// - Slave two-channel: bit positions beyond the sample are padded with zeros.
// - Slave two-channel: short channels cut the sample at the clocks received.
// - TDM sends four channels per frame; frame starts at frame sync rise.
// - TDM slot is 32 bit clocks, sample left-justified, MSB first.
// - TDM stream appears on data line one.
// - TDM: line three carries the inverted stream; all lines stay driven.
// - All formats selectable from pins and from registers.
// - Host enable set: pins ignored, configuration taken from registers only.
// - After reset: latch pins, start, send audio within 524288 master clocks.
`timescale 1ns/1ps
`include "sap_params.svh"
module sap_port #(
  parameter int SAMPLE_W       = 24,
  parameter int STARTUP_CYCLES = `SAP_STARTUP_MCLK
) (
  // Clock and reset
  input  wire logic                mclk,
  input  wire logic                nrst,
  // Configuration pins
  input  wire logic                mode_select_hi,
  input  wire logic                mode_select_lo,
  input  wire logic                format_select_hi,
  input  wire logic                format_select_lo,
  input  wire logic [2:0]          div_select,
  // Converter samples
  input  wire logic                sample_wr,
  input  wire logic [1:0]          sample_ch,
  input  wire logic [SAMPLE_W-1:0] sample_data,
  // Bit clock and frame clock pins
  input  wire logic                bclk_in,
  output logic                     bclk_out,
  output logic                     bclk_oe_n,
  input  wire logic                frame_clock_in,
  output logic                     frame_clock_out,
  output logic                     frame_clock_oe_n,
  // Serial data lines
  output logic                     data_out_one,
  output logic                     data_out_two,
  output logic                     data_out_three,
  output logic                     data_out_four,
  // Avalon-MM slave
  input  wire logic [3:0]          avs_address,
  input  wire logic                avs_read,
  input  wire logic                avs_write,
  input  wire logic [31:0]         avs_writedata,
  output logic      [31:0]         avs_readdata,
  output logic                     avs_waitrequest
);
  localparam int CW = $clog2(STARTUP_CYCLES + 1);

  // Start-up: pins caught one clock after reset release
  sap_pkg::sap_run_t run_st, next_run_st;
  logic [CW-1:0] start_cnt, next_start_cnt;
  logic [1:0]    pin_mode, next_pin_mode, pin_fmt, next_pin_fmt;
  logic [2:0]    pin_div, next_pin_div;
  logic          live;

  always_comb begin
    next_run_st    = run_st;
    next_start_cnt = start_cnt;
    next_pin_mode  = pin_mode;
    next_pin_fmt   = pin_fmt;
    next_pin_div   = pin_div;
    unique case (run_st)
      sap_pkg::SAP_RUN_LATCH: begin
        next_pin_mode  = {mode_select_hi, mode_select_lo};
        next_pin_fmt   = {format_select_hi, format_select_lo};
        next_pin_div   = div_select;
        next_start_cnt = '0;
        next_run_st    = sap_pkg::SAP_RUN_WAIT;
      end
      sap_pkg::SAP_RUN_WAIT: begin
        next_start_cnt = start_cnt + CW'(1);
        if (start_cnt == CW'(STARTUP_CYCLES - 1)) begin
          next_run_st = sap_pkg::SAP_RUN_LIVE;
        end
      end
      sap_pkg::SAP_RUN_LIVE: begin
        next_run_st = sap_pkg::SAP_RUN_LIVE;
      end
      default: begin
        next_run_st = sap_pkg::SAP_RUN_LATCH;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      run_st    <= sap_pkg::SAP_RUN_LATCH;
      start_cnt <= '0;
      pin_mode  <= 2'h0;
      pin_fmt   <= 2'h0;
      pin_div   <= 3'h0;
    end else begin
      run_st    <= next_run_st;
      start_cnt <= next_start_cnt;
      pin_mode  <= next_pin_mode;
      pin_fmt   <= next_pin_fmt;
      pin_div   <= next_pin_div;
    end
  end

  assign live = (run_st == sap_pkg::SAP_RUN_LIVE);

  // Effective configuration
  logic [7:0]           ctrl, next_ctrl;
  logic                 host_en, slave, tdm, i2s, first_lvl;
  logic [1:0]           eff_mode;
  logic [2:0]           eff_div;
  sap_pkg::sap_fmt_t    eff_fmt;
  sap_pkg::sap_speed_t  det_speed, next_det_speed, speed;

  always_comb begin
    host_en  = ctrl[`SAP_CTRL_HOST];
    // Pins are ignored entirely once the host has taken over
    eff_mode = host_en ? ctrl[`SAP_CTRL_MODE_LSB +: 2] : pin_mode;
    eff_fmt  = sap_pkg::sap_fmt_t'(host_en ? ctrl[`SAP_CTRL_FMT_LSB +: 2] : pin_fmt);
    eff_div  = host_en ? ctrl[`SAP_CTRL_DIV_LSB +: 3] : pin_div;
    slave    = (eff_mode == `SAP_MODE_SLAVE);
    speed    = slave ? det_speed : sap_pkg::sap_speed_t'(eff_mode);
    tdm      = (eff_fmt == sap_pkg::SAP_FMT_TDM);
    i2s      = (eff_fmt == sap_pkg::SAP_FMT_I2S);
    first_lvl = !i2s;
  end

  // Master clock divider as twice its ratio, so that 1.5 stays integral
  logic [3:0] ratio2;
  always_comb begin
    unique case (eff_div)
      3'h1:    ratio2 = 4'h3;
      3'h2:    ratio2 = 4'h4;
      3'h3:    ratio2 = 4'h6;
      3'h4:    ratio2 = 4'h8;
      default: ratio2 = 4'h2;
    endcase
  end

  // Divided internal master clock, as an enable pulse
  logic [3:0] div_acc, next_div_acc;
  logic       int_en, next_int_en;
  always_comb begin
    next_div_acc = div_acc + 4'h2;
    next_int_en  = 1'b0;
    if (next_div_acc >= ratio2) begin
      next_div_acc = next_div_acc - ratio2;
      next_int_en  = 1'b1;
    end
  end

  // Master clock generation; half period in master clocks, never below one.
  // Quad-rate TDM at every divider setting is limited to half the master clock rate.
  logic [11:0] hp_full, hp, hp_cnt, next_hp_cnt;
  logic [7:0]  mbit, next_mbit;
  logic        next_bclk, next_fclk, next_oe_n;
  always_comb begin
    hp_full     = 12'(ratio2) << (4'h8 - {2'h0, speed});
    hp          = hp_full >> (tdm ? `SAP_SHIFT_TDM : `SAP_SHIFT_2CH);
    if (hp == 12'h000) begin
      hp = 12'h001;
    end
    next_hp_cnt = hp_cnt;
    next_bclk   = bclk_out;
    next_fclk   = frame_clock_out;
    next_mbit   = mbit;
    next_oe_n   = slave;
    if (slave) begin
      next_hp_cnt = 12'h000;
    end else if (hp_cnt >= hp - 12'h001) begin
      next_hp_cnt = 12'h000;
      next_bclk   = !bclk_out;
      if (bclk_out) begin
        next_mbit = (mbit >= (tdm ? `SAP_LAST_BIT_TDM : `SAP_LAST_BIT_2CH)) ? 8'h00
                                                                        : mbit + 8'h01;
        // Frame clock moves only together with a falling bit clock
        next_fclk = tdm ? (next_mbit[7:5] == 3'h0) : (first_lvl ^ next_mbit[5]);
      end
    end else begin
      next_hp_cnt = hp_cnt + 12'h001;
    end
  end

  // Bit events seen on the active clocks
  logic       cur_b, cur_f, prev_b, f_at_fall, f_prev_m, fall, bound, f_rise;
  logic       ev_d1, ev_d2, half, next_half;
  logic [7:0] bit_cnt, next_bit_cnt;
  always_comb begin
    cur_b        = slave ? bclk_in : bclk_out;
    cur_f        = slave ? frame_clock_in : frame_clock_out;
    fall         = prev_b && !cur_b;
    f_rise       = cur_f && !f_prev_m;
    bound        = tdm ? (cur_f && !f_at_fall) : (cur_f != f_at_fall);
    next_bit_cnt = bit_cnt;
    next_half    = half;
    if (fall) begin
      next_half = (cur_f != first_lvl);
      if (bound) begin
        next_bit_cnt = 8'h00;
      end else if (bit_cnt != 8'hFF) begin
        next_bit_cnt = bit_cnt + 8'h01;
      end
    end
  end

  // Slave speed detector
  logic [15:0] det_cnt, next_det_cnt;
  always_comb begin
    next_det_cnt   = det_cnt;
    next_det_speed = det_speed;
    if (int_en && det_cnt != 16'hFFFF) begin
      next_det_cnt = det_cnt + 16'h0001;
    end
    if (f_rise) begin
      next_det_cnt = 16'h0000;
      if (det_cnt >= `SAP_DET_SINGLE_MIN) begin
        next_det_speed = sap_pkg::SAP_SPD_SINGLE;
      end else if (det_cnt >= `SAP_DET_DOUBLE_MIN) begin
        next_det_speed = sap_pkg::SAP_SPD_DOUBLE;
      end else begin
        next_det_speed = sap_pkg::SAP_SPD_QUAD;
      end
    end
  end

  // Sample fetch and serial data
  logic [1:0]          addr_a, addr_b;
  logic [SAMPLE_W-1:0] rd_a, rd_b;
  logic [8:0]          idx;
  logic                bit_ok, next_d1, next_d3;
  int                  sel;
  always_comb begin
    sel    = 0;
    addr_a = tdm ? bit_cnt[6:5] : {1'b0, half};
    addr_b = {1'b1, half};
    if (tdm) begin
      idx = {4'h0, bit_cnt[4:0]};
    end else if (i2s) begin
      idx = {1'b0, bit_cnt} - 9'h001;
    end else begin
      idx = {1'b0, bit_cnt};
    end
    // Past the sample, or past the last slot, the line carries zeros
    bit_ok = live && (eff_fmt != sap_pkg::SAP_FMT_RSVD) && (idx < 9'(SAMPLE_W)) &&
             !(tdm && bit_cnt[7]);
    next_d1 = data_out_one;
    next_d3 = data_out_three;
    if (ev_d2) begin
      next_d1 = 1'b0;
      next_d3 = 1'b0;
      if (bit_ok) begin
        sel     = SAMPLE_W - 1 - int'(idx);
        next_d1 = rd_a[sel];
        next_d3 = rd_b[sel];
      end
      if (tdm) begin
        next_d3 = !next_d1;
      end
    end
  end

  sap_sample_mem #(
    .W     (SAMPLE_W),
    .DEPTH (4),
    .AW    (2)
  ) u_mem (
    .mclk      (mclk),
    .nrst      (nrst),
    .wr        (sample_wr),
    .wr_addr   (sample_ch),
    .wr_data   (sample_data),
    .rd_addr_a (addr_a),
    .rd_addr_b (addr_b),
    .rd_data_a (rd_a),
    .rd_data_b (rd_b)
  );

  // Register slave: one wait cycle, then a one-cycle answer
  logic        next_wait, req;
  logic [31:0] next_rdata;
  always_comb begin
    req        = avs_read || avs_write;
    next_wait  = !(req && avs_waitrequest);
    next_rdata = avs_readdata;
    next_ctrl  = ctrl;
    if (req && avs_waitrequest) begin
      unique case (avs_address)
        `SAP_ADDR_CTRL:   next_rdata = {24'h000000, ctrl};
        `SAP_ADDR_STATUS: next_rdata = {23'h000000, eff_div, eff_fmt, live, slave, speed};
        default:          next_rdata = 32'h00000000;
      endcase
    end
    if (avs_write && !avs_waitrequest && avs_address == `SAP_ADDR_CTRL) begin
      next_ctrl = avs_writedata[7:0];
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ctrl             <= `SAP_CTRL_RESET;
      avs_waitrequest  <= 1'b1;
      avs_readdata     <= 32'h00000000;
      div_acc          <= 4'h0;
      int_en           <= 1'b0;
      hp_cnt           <= 12'h000;
      mbit             <= 8'h00;
      bclk_out         <= 1'b0;
      frame_clock_out  <= 1'b0;
      bclk_oe_n        <= 1'b1;
      frame_clock_oe_n <= 1'b1;
      prev_b           <= 1'b0;
      f_at_fall        <= 1'b0;
      f_prev_m         <= 1'b0;
      bit_cnt          <= 8'hFF;
      half             <= 1'b0;
      ev_d1            <= 1'b0;
      ev_d2            <= 1'b0;
      // Starts saturated: the false frame edge just after reset must not pick quad rate
      det_cnt          <= 16'hFFFF;
      det_speed        <= sap_pkg::SAP_SPD_SINGLE;
      data_out_one     <= 1'b0;
      data_out_two     <= 1'b0;
      data_out_three   <= 1'b0;
      data_out_four    <= 1'b0;
    end else begin
      ctrl             <= next_ctrl;
      avs_waitrequest  <= next_wait;
      avs_readdata     <= next_rdata;
      div_acc          <= next_div_acc;
      int_en           <= next_int_en;
      hp_cnt           <= next_hp_cnt;
      mbit             <= next_mbit;
      bclk_out         <= next_bclk;
      frame_clock_out  <= next_fclk;
      bclk_oe_n        <= next_oe_n;
      frame_clock_oe_n <= next_oe_n;
      prev_b           <= cur_b;
      f_at_fall        <= fall ? cur_f : f_at_fall;
      f_prev_m         <= cur_f;
      bit_cnt          <= next_bit_cnt;
      half             <= next_half;
      ev_d1            <= fall;
      ev_d2            <= ev_d1;
      det_cnt          <= next_det_cnt;
      det_speed        <= next_det_speed;
      data_out_one     <= next_d1;
      data_out_two     <= 1'b0;
      data_out_three   <= next_d3;
      data_out_four    <= 1'b0;
    end
  end

  property p_master_drive;
    @(posedge mclk) disable iff (!nrst) (nrst && !slave) |=> !bclk_oe_n && !frame_clock_oe_n;
  endproperty
  a_master_drive: assert property (p_master_drive)
    else $error("master mode does not drive the clocks");

  property p_slave_release;
    @(posedge mclk) disable iff (!nrst) slave [*2] |-> bclk_oe_n && frame_clock_oe_n;
  endproperty
  a_slave_release: assert property (p_slave_release)
    else $error("slave mode still drives the clocks");

  property p_frame_on_fall;
    @(posedge mclk) disable iff (!nrst)
      (!slave && !$past(slave) && $changed(frame_clock_out)) |-> $fell(bclk_out);
  endproperty
  a_frame_on_fall: assert property (p_frame_on_fall)
    else $error("frame clock moved away from a bit clock fall");

  property p_pad_zero;
    @(posedge mclk) disable iff (!nrst) (ev_d2 && !tdm && idx >= 9'(SAMPLE_W)) |=> !data_out_one;
  endproperty
  a_pad_zero: assert property (p_pad_zero)
    else $error("bit past the sample is not zero");

  property p_tdm_inverse;
    @(posedge mclk) disable iff (!nrst) (ev_d2 && tdm) |=> data_out_three == !data_out_one;
  endproperty
  a_tdm_inverse: assert property (p_tdm_inverse)
    else $error("line three is not the inverted TDM stream");

  property p_quiet_start;
    @(posedge mclk) disable iff (!nrst) !live |=> !data_out_one && !data_out_two;
  endproperty
  a_quiet_start: assert property (p_quiet_start)
    else $error("data sent before start-up ended");

  property p_detect_single;
    @(posedge mclk) disable iff (!nrst)
      (f_rise && det_cnt >= `SAP_DET_SINGLE_MIN) |=> det_speed == sap_pkg::SAP_SPD_SINGLE;
  endproperty
  a_detect_single: assert property (p_detect_single)
    else $error("ratio not classified as single rate");

  property p_tdm_frame;
    @(posedge mclk) disable iff (!nrst) (fall && tdm && cur_f && !f_at_fall) |=> bit_cnt == 8'h00;
  endproperty
  a_tdm_frame: assert property (p_tdm_frame)
    else $error("TDM frame did not restart at frame sync rise");
endmodule : sap_port

/* sim/sap_clk_source.sv */
// Far-side clock master that feeds bit and frame clocks to the port in slave mode
`timescale 1ns/1ps
module sap_clk_source (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       nrst,
  // Frame shape
  input  wire logic       run,
  input  wire logic       tdm,
  input  wire logic [8:0] nbits,
  // Clocks to the port
  output logic            bclk,
  output logic            frame
);
  // Half bit clock in master clocks; the port needs at least 4
  localparam int HALF = 6;
  logic [3:0] hcnt;
  logic [8:0] bitcnt;
  // Both clocks are counted off mclk, so they stay locked to the port's clock
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      hcnt   <= 4'h0;
      bclk   <= 1'b0;
      bitcnt <= 9'h000;
    end else if (!run) begin
      hcnt   <= 4'h0;
      bclk   <= 1'b0;
      bitcnt <= 9'h000;
    end else if (hcnt == 4'(HALF - 1)) begin
      hcnt <= 4'h0;
      bclk <= ~bclk;
      if (bclk) begin
        bitcnt <= (bitcnt >= nbits - 9'h001) ? 9'h000 : bitcnt + 9'h001;
      end
    end else begin
      hcnt <= hcnt + 4'h1;
    end
  end
  // Frame edges land on bit clock falling edges
  assign frame = tdm ? (bitcnt == 9'h000) : (bitcnt < (nbits >> 1));
endmodule : sap_clk_source

/* sim/sap_port_test.sv */
// Self-checking bench for the serial audio port
`timescale 1ns/1ps
module sap_port_test;
  logic        mclk = 1'b0;
  logic        nrst = 1'b0;
  logic [1:0]  mode = 2'h0;
  logic [1:0]  fmt = 2'h0;
  logic [2:0]  div = 3'h4;
  logic        sample_wr = 1'b0;
  logic [1:0]  sample_ch = 2'h0;
  logic [23:0] sample_data = 24'h000000;
  logic        bclk_in, frame_clock_in, bclk_out, bclk_oe_n, frame_clock_out, frame_clock_oe_n;
  logic        d1, d2, d3, d4, bc, fc;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, rd;
  logic        avs_waitrequest;
  logic        run = 1'b0, tdm = 1'b0, i2s = 1'b0, slave = 1'b0;
  logic [8:0]  nbits = 9'h040;
  int          num_errors = 0, n_compared = 0, cap_w = 24, bit_idx = 99;
  integer      seed = 32'hCC05BE5A;
  logic [23:0] smp [4];
  logic [31:0] exp_q [$];
  logic [31:0] word = 32'h0;
  logic        bc_q = 1'b0, fc_q = 1'b0, d1_q = 1'b0, d3_q = 1'b1, armed = 1'b0;

  always #5 mclk = ~mclk;

  sap_port #(.SAMPLE_W(24), .STARTUP_CYCLES(16)) i_dut (
    .mclk(mclk), .nrst(nrst), .mode_select_hi(mode[1]), .mode_select_lo(mode[0]),
    .format_select_hi(fmt[1]), .format_select_lo(fmt[0]), .div_select(div),
    .sample_wr(sample_wr), .sample_ch(sample_ch), .sample_data(sample_data),
    .bclk_in(bclk_in), .bclk_out(bclk_out), .bclk_oe_n(bclk_oe_n),
    .frame_clock_in(frame_clock_in), .frame_clock_out(frame_clock_out),
    .frame_clock_oe_n(frame_clock_oe_n), .data_out_one(d1), .data_out_two(d2),
    .data_out_three(d3), .data_out_four(d4), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

  sap_clk_source i_src (.mclk(mclk), .nrst(nrst), .run(run), .tdm(tdm), .nbits(nbits),
    .bclk(bclk_in), .frame(frame_clock_in));

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %0t register read %h expected %h", $time, got, exp);
    end
  endtask : chk_reg

  task automatic chk_line(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %0t line value %h expected %h", $time, got, exp);
    end
  endtask : chk_line

  function automatic logic [31:0] st(input logic [1:0] s, input logic v,
                                     input logic [1:0] f, input logic [2:0] d);
    return {23'h0, d, f, 1'b1, v, s};
  endfunction : st

  // Holds the request until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    avs_address   <= a;
    avs_writedata <= wd;
    avs_write     <= wr;
    avs_read      <= ~wr;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0 && n < 50) begin
      @(posedge mclk);
      n++;
    end
    if (n == 50) begin
      num_errors++;
      $display("MISMATCH %0t bus answer missing", $time);
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge mclk);
  endtask : bus

  task automatic put_samples;
    for (int c = 0; c < 4; c++) begin
      smp[c] = 24'($random(seed));
      sample_ch   <= c[1:0];
      sample_data <= smp[c];
      sample_wr   <= 1'b1;
      @(posedge mclk);
    end
    sample_wr <= 1'b0;
    @(posedge mclk);
  endtask : put_samples

  // Notes one expected first-channel word and waits until the monitor has taken it
  task automatic expect_word(input int w, input logic [31:0] e);
    int n;
    n = 0;
    cap_w = w;
    exp_q.push_back(e);
    while (exp_q.size() > 0 && n < 20000) begin
      @(posedge mclk);
      n++;
    end
    if (n == 20000) begin
      num_errors++;
      $display("MISMATCH %0t no serial word seen", $time);
    end
  endtask : expect_word

  task automatic slave_case(input logic [1:0] f, input logic [2:0] d, input logic [8:0] nb,
                            input int w, input logic [1:0] spd, input logic [31:0] e);
    bus(1'b1, 4'h0, {24'h0, 1'b1, d, f, 2'h3});
    nbits <= nb;
    tdm   <= (f == 2'h2);
    i2s   <= (f == 2'h1);
    slave <= 1'b1;
    run   <= 1'b1;
    repeat (7000) @(posedge mclk);
    bus(1'b0, 4'h4, 32'h0);
    chk_reg(rd & 32'h1FF, st(spd, 1'b1, f, d));
    chk_line({30'h0, bclk_oe_n, frame_clock_oe_n}, 32'h3);
    expect_word(w, e);
  endtask : slave_case

  task automatic results;
    $display("Comparisons %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : results

  // Samples just before each rising bit clock, as the receiver would
  always @(negedge mclk) begin
    bc = slave ? bclk_in : bclk_out;
    fc = slave ? frame_clock_in : frame_clock_out;
    if (i2s ? (!fc && fc_q) : (fc && !fc_q)) begin
      bit_idx = i2s ? -1 : 0;
      word = 32'h0;
      armed = (exp_q.size() > 0);
    end
    if (bc && !bc_q && armed) begin
      if (bit_idx >= 0 && bit_idx < cap_w) begin
        word = {word[30:0], d1_q};
        if (tdm) chk_line({31'h0, d3_q}, {31'h0, ~d1_q});
        else chk_line({30'h0, d2, d4}, 32'h0);
        if (bit_idx == cap_w - 1) chk_line(word, exp_q.pop_front());
      end
      bit_idx++;
    end
    bc_q = bc;
    fc_q = fc;
    d1_q = d1;
    d3_q = d3;
  end

  initial begin
    repeat (90000) @(posedge mclk);
    num_errors++;
    $display("MISMATCH %0t watchdog expired", $time);
    results();
  end

  initial begin
    repeat (3) @(posedge mclk);
    chk_line({29'h0, bclk_oe_n, avs_waitrequest, d1}, 32'h6);
    nrst <= 1'b1;
    @(posedge mclk);
    // A write to an unmapped address must leave the control word alone
    bus(1'b1, 4'h8, 32'h000000FF);
    bus(1'b0, 4'h0, 32'h0);
    chk_reg(rd, 32'h0);
    bus(1'b0, 4'h8, 32'h0);
    chk_reg(rd, 32'h0);
    repeat (20) @(posedge mclk);
    bus(1'b0, 4'h4, 32'h0);
    chk_reg(rd & 32'h1FF, st(2'h0, 1'b0, 2'h0, 3'h4));
    chk_line({30'h0, bclk_oe_n, frame_clock_oe_n}, 32'h0);
    put_samples();
    expect_word(24, {8'h0, smp[0]});
    // Pins now select slave and reserved; host enable is clear, so they are used
    mode <= 2'h3;
    fmt  <= 2'h3;
    // A second reset latches the slave and reserved straps
    nrst <= 1'b0;
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
    repeat (24) @(posedge mclk);
    bus(1'b0, 4'h4, 32'h0);
    chk_reg(rd & 32'h1FF, st(2'h0, 1'b1, 2'h3, 3'h4));
    chk_line({30'h0, bclk_oe_n, frame_clock_oe_n}, 32'h3);
    for (int m = 0; m < 3; m++) begin
      bus(1'b1, 4'h0, {24'h0, 1'b1, 3'h4, 2'h0, m[1:0]});
      bus(1'b0, 4'h4, 32'h0);
      chk_reg(rd & 32'h1FF, st(m[1:0], 1'b0, 2'h0, 3'h4));
    end
    slave_case(2'h2, 3'h0, 9'h100, 24, 2'h0, {8'h0, smp[0]});
    slave_case(2'h0, 3'h3, 9'h020, 16, 2'h1, {16'h0, smp[0][23:8]});
    slave_case(2'h0, 3'h4, 9'h010, 8, 2'h2, {24'h0, smp[0][23:16]});
    slave_case(2'h1, 3'h4, 9'h060, 32, 2'h0, {smp[0], 8'h00});
    slave_case(2'h3, 3'h2, 9'h040, 24, 2'h0, 32'h0);
    results();
  end
endmodule : sap_port_test
